// >>> design/lpcs_pkg.sv
// package: register map, field layout, timing and state types of the line supervisor
package lpcs_pkg;
  // direct register offsets
  localparam logic [7:0] ADDR_IND_DATA_LO = 8'h1c;
  localparam logic [7:0] ADDR_IND_DATA_HI = 8'h1d;
  localparam logic [7:0] ADDR_IND_READ    = 8'h1e;
  localparam logic [7:0] ADDR_IND_WRITE   = 8'h1f;
  localparam logic [7:0] ADDR_PENDING     = 8'h13;
  localparam logic [7:0] ADDR_ENABLE      = 8'h16;
  localparam logic [7:0] ADDR_LINEFEED    = 8'h40;
  localparam logic [7:0] ADDR_AUTO_OPEN   = 8'h43;
  localparam logic [7:0] ADDR_LC_STATUS   = 8'h44;
  localparam logic [7:0] ADDR_LC_DEBOUNCE = 8'h45;
  localparam logic [7:0] ADDR_PWR_SELECT  = 8'h4c;
  localparam logic [7:0] ADDR_PWR_READ    = 8'h4d;
  localparam logic [7:0] ADDR_CAL_CTRL    = 8'h60;
  localparam logic [7:0] ADDR_LC_MODE     = 8'h6c;
  // indirect register indices
  localparam logic [7:0] IND_LC_THR_UP  = 8'h1c;
  localparam logic [7:0] IND_PWR_THR12  = 8'h20;
  localparam logic [7:0] IND_PWR_THR34  = 8'h21;
  localparam logic [7:0] IND_PWR_THR56  = 8'h22;
  localparam logic [7:0] IND_LC_COEF    = 8'h23;
  localparam logic [7:0] IND_POLE12     = 8'h25;
  localparam logic [7:0] IND_POLE34     = 8'h26;
  localparam logic [7:0] IND_POLE56     = 8'h27;
  localparam logic [7:0] IND_LC_THR_LO  = 8'h2b;
  // field positions
  localparam int BIT_LC_PENDING = 1;
  localparam int BIT_Q1_ALARM   = 2;
  localparam int BIT_AUTO_OPEN  = 0;
  localparam int BIT_LC_STATUS  = 0;
  localparam int BIT_CAL        = 7;
  localparam int BIT_HYST_EN    = 0;
  localparam int BIT_VOLT_EN    = 2;
  // reset values
  localparam logic [7:0]  RST_REG8  = 8'h00;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  // timing
  localparam longint CLK_HZ       = 200_000_000;
  localparam longint SAMPLE_HZ    = 800;
  localparam longint SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam longint CAL_TIME_US  = 1000;
  localparam longint CAL_CYCLES   = (CAL_TIME_US * CLK_HZ) / 1_000_000;
  localparam int TICK_W = 18;
  localparam int CAL_W  = 24;
  // filter scaling
  localparam int PWR_SHIFT  = 15;
  localparam int LOOP_SHIFT = 13;
  // linefeed states
  typedef enum logic [2:0] {
    LF_OPEN       = 3'h0,
    LF_FWD_ACTIVE = 3'h1,
    LF_FWD_OHT    = 3'h2,
    LF_TIP_OPEN   = 3'h3,
    LF_RINGING    = 3'h4,
    LF_REV_ACTIVE = 3'h5,
    LF_REV_OHT    = 3'h6,
    LF_RING_OPEN  = 3'h7
  } lpcs_lf_state_t;
  // monitor converter samples
  typedef struct packed {
    logic [5:0][7:0] q_power;
    logic            loop_i_sign;
    logic [5:0]      loop_i_mag;
    logic            loop_v_sign;
    logic [5:0]      loop_v_mag;
  } lpcs_sample_t;
  // register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lpcs_bus_t;
endpackage

// >>> design/lpcs_supervisor.sv
// line power and loop closure supervisor: register file, thermal and loop filters
`timescale 1ns/1ps
// Function
// (R1) select 0..5 picks transistor one..six
// (R2) readback returns selected transistor realtime power
// (R3) low-pass each power, compare pair threshold
// (R4) per-pair 12-bit pole, 800 Hz update; the code keeps 16-bit poles
// (R5) separate thresholds for pairs 12, 34, 56
// (R6) over threshold sets alarm pending, irq
// (R7) alarm bits 2..7 map transistors one..six
// (R8) auto-open bit forces open on alarm
// (R9) loop processing only in on-hook states
// (R10) loop sample low-pass, 13-bit coefficient
// (R11) filtered loop vs six-bit threshold
// (R12) debounce flips after full opposite interval
// (R13) debounce result sets status, posts irq
// (R14) hysteresis uses upper and lower thresholds
// (R15) voltage mode compares minimum loop voltage
// (R16) voltage hysteresis: upper and lower voltage
// (R17) software prefers current-based detection
// (R18) calibration bit self-clears when finished
// (R19) linefeed starts open after reset
// (R20) software calibrates once after power-up
// (R21) calibration overrides battery, tip, ring targets
// (R22) samples refresh at 800 Hz, sign-magnitude
// (R23) open state removes all transistor drive
// (R24) pending sticky until cleared, irq ORs
module lpcs_supervisor #(
  parameter logic [lpcs_pkg::TICK_W-1:0] TICK_CYCLES =
    lpcs_pkg::TICK_W'(lpcs_pkg::SAMPLE_CYCLES),
  parameter logic [lpcs_pkg::CAL_W-1:0]  CAL_CYCLES  =
    lpcs_pkg::CAL_W'(lpcs_pkg::CAL_CYCLES)
) (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_N,
  input  wire lpcs_pkg::lpcs_bus_t   BUS,
  input  wire lpcs_pkg::lpcs_sample_t SAMPLE,
  output logic [7:0]                 RDATA,
  output logic                       IRQ,
  output lpcs_pkg::lpcs_lf_state_t   LINEFEED_STATE,
  output logic                       DRIVE_ENABLE,
  output logic                       CAL_ACTIVE,
  output logic                       CAL_TARGET_OVERRIDE,
  output logic                       SAMPLE_TICK
);

  typedef struct packed {
    logic [7:0]                 rdata;
    logic                       irq;
    lpcs_pkg::lpcs_lf_state_t   lf_state;
    logic                       drive_en;
    logic                       cal_busy;
    logic                       tick;
    logic [lpcs_pkg::TICK_W-1:0] tick_cnt;
    logic [lpcs_pkg::CAL_W-1:0]  cal_cnt;
    logic [7:0]                 pending;
    logic [7:0]                 enable;
    logic                       auto_open;
    logic [6:0]                 debounce;
    logic [2:0]                 sel;
    logic                       hyst_en;
    logic                       volt_en;
    logic [7:0]                 ind_addr;
    logic [15:0]                ind_data;
    logic [2:0][15:0]           pwr_thr;
    logic [2:0][15:0]           pole;
    logic [5:0]                 lc_up;
    logic [5:0]                 lc_lo;
    logic [12:0]                lc_coef;
    logic [5:0][15:0]           pwr_filt;
    logic [5:0][7:0]            q_last;
    logic [15:0]                loop_filt;
    logic                       cmp;
    logic                       lc_status;
    logic [6:0]                 db_cnt;
  } lpcs_state_t;

  lpcs_state_t r;
  lpcs_state_t next_r;

  logic [5:0][15:0] filt_step;
  logic [5:0]       over_thr;

  // per-transistor thermal filter; pair index is transistor / 2
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_q
      localparam int PAIR = gi / 2;
      logic signed [16:0] diff;
      logic signed [33:0] prod;
      logic signed [16:0] sum;
      assign diff = $signed({2'b00, r.q_last[gi], 7'h00}) - $signed({1'b0, r.pwr_filt[gi]});
      assign prod = diff * $signed({1'b0, r.pole[PAIR]});                  // [R3] [R4]
      assign sum  = $signed({1'b0, r.pwr_filt[gi]}) + prod[lpcs_pkg::PWR_SHIFT +: 17];
      assign filt_step[gi] = sum[16] ? 16'h0000 : sum[15:0];
      assign over_thr[gi]  = r.pwr_filt[gi] > r.pwr_thr[PAIR];             // [R3] [R5]
    end
  endgenerate

  // loop filter on the sign-stripped magnitude
  logic [5:0]         loop_mag;
  logic signed [16:0] loop_diff;
  logic signed [30:0] loop_prod;
  logic signed [16:0] loop_sum;
  logic [15:0]        loop_next;
  logic [5:0]         loop_lvl;
  logic               loop_run;

  assign loop_mag  = r.volt_en ? SAMPLE.loop_v_mag : SAMPLE.loop_i_mag;    // [R15] [R22]
  assign loop_diff = $signed({3'b000, loop_mag, 8'h00}) - $signed({1'b0, r.loop_filt});
  assign loop_prod = loop_diff * $signed({1'b0, r.lc_coef});               // [R10]
  assign loop_sum  = $signed({1'b0, r.loop_filt}) + loop_prod[lpcs_pkg::LOOP_SHIFT +: 17];
  assign loop_next = loop_sum[16] ? 16'h0000 : loop_sum[15:0];
  assign loop_lvl  = r.loop_filt[13:8];
  // only the on-hook active and transmission states; calibration suspends it
  assign loop_run  = !r.cal_busy &&
                     (r.lf_state == lpcs_pkg::LF_FWD_ACTIVE ||
                      r.lf_state == lpcs_pkg::LF_FWD_OHT ||
                      r.lf_state == lpcs_pkg::LF_REV_ACTIVE ||
                      r.lf_state == lpcs_pkg::LF_REV_OHT);                 // [R9]

  always_comb
  begin
    logic       wr;
    logic       rd;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] set;
    logic [7:0] clr;
    logic       alarm;
    logic       cmp_new;
    wr      = BUS.wr;
    rd      = BUS.rd;
    a       = BUS.addr;
    d       = BUS.wdata;
    set     = 8'h00;
    clr     = 8'h00;
    alarm   = 1'b0;
    cmp_new = r.cmp;
    next_r  = r;
    next_r.rdata = 8'h00;

    // monitor sample rate
    next_r.tick = 1'b0;
    if (r.tick_cnt >= TICK_CYCLES - 1'b1)
    begin
      next_r.tick_cnt = '0;
      next_r.tick     = 1'b1;                                              // [R22]
    end
    else
    begin
      next_r.tick_cnt = r.tick_cnt + 1'b1;
    end

    if (r.tick)
    begin
      next_r.q_last   = SAMPLE.q_power;                                    // [R22]
      next_r.pwr_filt = filt_step;                                         // [R4]
      for (int i = 0; i < 6; i++)
      begin
        if (over_thr[i])
        begin
          set[lpcs_pkg::BIT_Q1_ALARM + i] = 1'b1;                          // [R6] [R7]
          alarm = 1'b1;
        end
      end
      if (loop_run)
      begin
        next_r.loop_filt = loop_next;
        // closed when current is high or, in voltage mode, voltage is low
        if (!r.volt_en)
        begin
          if (!r.hyst_en)
            cmp_new = loop_lvl > r.lc_up;                                  // [R11]
          else if (r.cmp)
            cmp_new = loop_lvl > r.lc_lo;                                  // [R14]
          else
            cmp_new = loop_lvl > r.lc_up;                                  // [R14]
        end
        else
        begin
          if (!r.hyst_en)
            cmp_new = loop_lvl < r.lc_up;                                  // [R15]
          else if (r.cmp)
            cmp_new = loop_lvl < r.lc_up;                                  // [R16]
          else
            cmp_new = loop_lvl < r.lc_lo;                                  // [R16]
        end
        next_r.cmp = cmp_new;
        // a zero interval passes the comparator through on the next tick
        if (r.cmp == r.lc_status)
        begin
          next_r.db_cnt = 7'h00;
        end
        else if (r.db_cnt >= r.debounce)
        begin
          next_r.lc_status = r.cmp;                                        // [R12] [R13]
          next_r.db_cnt    = 7'h00;
          set[lpcs_pkg::BIT_LC_PENDING] = 1'b1;                            // [R13]
        end
        else
        begin
          next_r.db_cnt = r.db_cnt + 1'b1;                                 // [R12]
        end
      end
    end

    // calibration sequence timer
    if (r.cal_busy)
    begin
      if (r.cal_cnt >= CAL_CYCLES - 1'b1)
      begin
        next_r.cal_busy = 1'b0;                                            // [R18]
        next_r.cal_cnt  = '0;
      end
      else
      begin
        next_r.cal_cnt = r.cal_cnt + 1'b1;
      end
    end

    // register writes
    if (wr)
    begin
      if (a == lpcs_pkg::ADDR_PENDING)
        clr = d;
      else if (a == lpcs_pkg::ADDR_ENABLE)
        next_r.enable = d;
      else if (a == lpcs_pkg::ADDR_LINEFEED)
        next_r.lf_state = lpcs_pkg::lpcs_lf_state_t'(d[2:0]);
      else if (a == lpcs_pkg::ADDR_AUTO_OPEN)
        next_r.auto_open = d[lpcs_pkg::BIT_AUTO_OPEN];
      else if (a == lpcs_pkg::ADDR_LC_DEBOUNCE)
        next_r.debounce = d[6:0];
      else if (a == lpcs_pkg::ADDR_PWR_SELECT)
        next_r.sel = d[2:0];
      else if (a == lpcs_pkg::ADDR_CAL_CTRL)
      begin
        if (d[lpcs_pkg::BIT_CAL] && !r.cal_busy)
        begin
          next_r.cal_busy = 1'b1;                                          // [R18]
          next_r.cal_cnt  = '0;
        end
      end
      else if (a == lpcs_pkg::ADDR_LC_MODE)
      begin
        next_r.hyst_en = d[lpcs_pkg::BIT_HYST_EN];                         // [R14]
        next_r.volt_en = d[lpcs_pkg::BIT_VOLT_EN];                         // [R15]
      end
      else if (a == lpcs_pkg::ADDR_IND_DATA_LO)
        next_r.ind_data[7:0] = d;
      else if (a == lpcs_pkg::ADDR_IND_DATA_HI)
        next_r.ind_data[15:8] = d;
      else if (a == lpcs_pkg::ADDR_IND_READ)
      begin
        next_r.ind_addr = d;
        if (d == lpcs_pkg::IND_PWR_THR12)
          next_r.ind_data = r.pwr_thr[0];
        else if (d == lpcs_pkg::IND_PWR_THR34)
          next_r.ind_data = r.pwr_thr[1];
        else if (d == lpcs_pkg::IND_PWR_THR56)
          next_r.ind_data = r.pwr_thr[2];
        else if (d == lpcs_pkg::IND_POLE12)
          next_r.ind_data = r.pole[0];
        else if (d == lpcs_pkg::IND_POLE34)
          next_r.ind_data = r.pole[1];
        else if (d == lpcs_pkg::IND_POLE56)
          next_r.ind_data = r.pole[2];
        else if (d == lpcs_pkg::IND_LC_THR_UP)
          next_r.ind_data = {10'h000, r.lc_up};
        else if (d == lpcs_pkg::IND_LC_THR_LO)
          next_r.ind_data = {10'h000, r.lc_lo};
        else if (d == lpcs_pkg::IND_LC_COEF)
          next_r.ind_data = {3'h0, r.lc_coef};
        else
          next_r.ind_data = 16'h0000;
      end
      else if (a == lpcs_pkg::ADDR_IND_WRITE)
      begin
        next_r.ind_addr = d;
        if (d == lpcs_pkg::IND_PWR_THR12)
          next_r.pwr_thr[0] = r.ind_data;                                  // [R5]
        else if (d == lpcs_pkg::IND_PWR_THR34)
          next_r.pwr_thr[1] = r.ind_data;                                  // [R5]
        else if (d == lpcs_pkg::IND_PWR_THR56)
          next_r.pwr_thr[2] = r.ind_data;                                  // [R5]
        else if (d == lpcs_pkg::IND_POLE12)
          next_r.pole[0] = r.ind_data;                                     // [R4]
        else if (d == lpcs_pkg::IND_POLE34)
          next_r.pole[1] = r.ind_data;                                     // [R4]
        else if (d == lpcs_pkg::IND_POLE56)
          next_r.pole[2] = r.ind_data;                                     // [R4]
        else if (d == lpcs_pkg::IND_LC_THR_UP)
          next_r.lc_up = r.ind_data[5:0];                                  // [R11]
        else if (d == lpcs_pkg::IND_LC_THR_LO)
          next_r.lc_lo = r.ind_data[5:0];                                  // [R14]
        else if (d == lpcs_pkg::IND_LC_COEF)
          next_r.lc_coef = r.ind_data[12:0];                               // [R10]
      end
    end

    // an alarm wins over a linefeed write in the same cycle
    if (alarm && r.auto_open)
      next_r.lf_state = lpcs_pkg::LF_OPEN;                                 // [R8]
    next_r.drive_en = next_r.lf_state != lpcs_pkg::LF_OPEN;               // [R23]

    // set wins over a write-one clear
    next_r.pending = (r.pending & ~clr) | set;                            // [R24]
    next_r.irq     = |(next_r.pending & next_r.enable);                    // [R6] [R13] [R24]

    // register reads, data in the following cycle
    if (rd)
    begin
      if (a == lpcs_pkg::ADDR_PENDING)
        next_r.rdata = r.pending;
      else if (a == lpcs_pkg::ADDR_ENABLE)
        next_r.rdata = r.enable;
      else if (a == lpcs_pkg::ADDR_LINEFEED)
        next_r.rdata = {5'h00, r.lf_state};
      else if (a == lpcs_pkg::ADDR_AUTO_OPEN)
        next_r.rdata = {7'h00, r.auto_open};
      else if (a == lpcs_pkg::ADDR_LC_STATUS)
        next_r.rdata = {7'h00, r.lc_status};                               // [R13]
      else if (a == lpcs_pkg::ADDR_LC_DEBOUNCE)
        next_r.rdata = {1'b0, r.debounce};
      else if (a == lpcs_pkg::ADDR_PWR_SELECT)
        next_r.rdata = {5'h00, r.sel};
      else if (a == lpcs_pkg::ADDR_PWR_READ)
        next_r.rdata = (r.sel < 3'h6) ? r.q_last[r.sel] : 8'h00;           // [R1] [R2]
      else if (a == lpcs_pkg::ADDR_CAL_CTRL)
        next_r.rdata = {r.cal_busy, 7'h00};                                // [R18]
      else if (a == lpcs_pkg::ADDR_LC_MODE)
        next_r.rdata = {5'h00, r.volt_en, 1'b0, r.hyst_en};
      else if (a == lpcs_pkg::ADDR_IND_DATA_LO)
        next_r.rdata = r.ind_data[7:0];
      else if (a == lpcs_pkg::ADDR_IND_DATA_HI)
        next_r.rdata = r.ind_data[15:8];
      else if (a == lpcs_pkg::ADDR_IND_READ || a == lpcs_pkg::ADDR_IND_WRITE)
        next_r.rdata = r.ind_addr;
      else
        next_r.rdata = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      r          <= '0;
      r.lf_state <= lpcs_pkg::LF_OPEN;                                     // [R19]
      r.pending  <= lpcs_pkg::RST_REG8;
      r.enable   <= lpcs_pkg::RST_REG8;
      r.pwr_thr  <= {3{lpcs_pkg::RST_REG16}};
      r.pole     <= {3{lpcs_pkg::RST_REG16}};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign RDATA               = r.rdata;
  assign IRQ                 = r.irq;
  assign LINEFEED_STATE      = r.lf_state;
  assign DRIVE_ENABLE        = r.drive_en;
  assign CAL_ACTIVE          = r.cal_busy;
  assign CAL_TARGET_OVERRIDE = r.cal_busy;                                // [R21]
  assign SAMPLE_TICK         = r.tick;

endmodule

// >>> tb/lpcs_supervisor_asserts.sv
// checker: port-level timing relations of the line supervisor
`timescale 1ns/1ps
module lpcs_supervisor_asserts #(
  parameter logic [lpcs_pkg::TICK_W-1:0] TICK_CYCLES =
    lpcs_pkg::TICK_W'(lpcs_pkg::SAMPLE_CYCLES),
  parameter logic [lpcs_pkg::CAL_W-1:0]  CAL_CYCLES  =
    lpcs_pkg::CAL_W'(lpcs_pkg::CAL_CYCLES)
) (
  input wire logic                     REF_CLK,
  input wire logic                     RST_N,
  input wire lpcs_pkg::lpcs_bus_t      BUS,
  input wire lpcs_pkg::lpcs_sample_t   SAMPLE,
  input wire logic [7:0]               RDATA,
  input wire logic                     IRQ,
  input wire lpcs_pkg::lpcs_lf_state_t LINEFEED_STATE,
  input wire logic                     DRIVE_ENABLE,
  input wire logic                     CAL_ACTIVE,
  input wire logic                     CAL_TARGET_OVERRIDE,
  input wire logic                     SAMPLE_TICK
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);
  int   gap;
  int   cal_len;
  logic seen_tick;
  // the first tick after reset is counted from reset, not from a tick, so spacing is judged from the second
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      gap <= 0;
      cal_len <= 0;
      seen_tick <= 1'b0;
    end
    else
    begin
      gap <= SAMPLE_TICK ? 0 : gap + 1;
      cal_len <= CAL_ACTIVE ? cal_len + 1 : 0;
      seen_tick <= seen_tick | SAMPLE_TICK;
    end
  end
  chk_tick_spacing: assert property (SAMPLE_TICK && seen_tick |-> gap == int'(TICK_CYCLES) - 1)
    else $error("monitor tick spacing wrong");
  chk_tick_pulse: assert property (SAMPLE_TICK |=> !SAMPLE_TICK)
    else $error("monitor tick longer than one cycle");
  chk_open_drive: assert property (DRIVE_ENABLE == (LINEFEED_STATE != lpcs_pkg::LF_OPEN))
    else $error("drive enable disagrees with linefeed state");
  chk_reset_open: assert property ($rose(RST_N) |-> LINEFEED_STATE == lpcs_pkg::LF_OPEN && !DRIVE_ENABLE)
    else $error("linefeed not open after reset");
  chk_cal_start: assert property (BUS.wr && BUS.addr == lpcs_pkg::ADDR_CAL_CTRL && BUS.wdata[7]
    && !CAL_ACTIVE |=> CAL_ACTIVE)
    else $error("calibration did not start");
  chk_cal_length: assert property ($fell(CAL_ACTIVE) |-> cal_len == int'(CAL_CYCLES))
    else $error("calibration length wrong");
  chk_cal_readback: assert property (BUS.rd && BUS.addr == lpcs_pkg::ADDR_CAL_CTRL
    |=> RDATA[7] == $past(CAL_ACTIVE))
    else $error("calibration bit readback wrong");
  chk_cal_override: assert property (CAL_TARGET_OVERRIDE == CAL_ACTIVE)
    else $error("target override not tied to calibration");
  chk_rdata_idle: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  chk_irq_cause: assert property ($rose(IRQ) |-> $past(SAMPLE_TICK) || $past(BUS.wr))
    else $error("interrupt rose without tick or write");
  chk_auto_open: assert property ($fell(DRIVE_ENABLE) |-> $past(SAMPLE_TICK) || $past(BUS.wr))
    else $error("linefeed opened without tick or write");
  cover property ($fell(CAL_ACTIVE));
  cover property ($rose(IRQ));
  cover property ($fell(DRIVE_ENABLE) && !$past(BUS.wr));
  cover property (SAMPLE_TICK && seen_tick);
endmodule

// >>> tb/lpcs_supervisor_tb.sv
// testbench: register, power alarm, loop closure and calibration scenarios
`timescale 1ns/1ps
module lpcs_supervisor_tb;
  localparam int TK = 20;
  localparam int CK = 10;
  logic                     ref_clk = 1'b0;
  logic                     rst_n = 1'b0;
  lpcs_pkg::lpcs_bus_t      bus = '0;
  lpcs_pkg::lpcs_sample_t   smp = '0;
  logic [7:0]               rdata;
  logic                     irq;
  lpcs_pkg::lpcs_lf_state_t lf;
  logic                     drv_en;
  logic                     cal_act;
  logic                     cal_ovr;
  logic                     tick;
  int                       bad_count = 0;
  int                       num_checks = 0;
  int                       seed = 32'hc71e;
  logic [7:0]               d;
  logic [7:0]               v;
  logic [7:0] regs [9] = '{8'h13, 8'h16, 8'h43, 8'h44, 8'h45, 8'h4c, 8'h60, 8'h6c, 8'h55};
  logic [7:0] rw_a [5] = '{8'h16, 8'h45, 8'h4c, 8'h6c, 8'h43};
  logic [7:0] rw_m [5] = '{8'hff, 8'h7f, 8'h07, 8'h05, 8'h01};
  logic [7:0] lm [9] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'h01, 8'h00, 8'h05, 8'h05, 8'h05};
  logic [5:0] lg [9] = '{6'd40, 6'd40, 6'd5, 6'd15, 6'd15, 6'd15, 6'd15, 6'd5, 6'd15};
  logic [8:0] le = 9'b110011101;
  always #2.5 ref_clk = ~ref_clk;
  lpcs_supervisor #(
    .TICK_CYCLES(lpcs_pkg::TICK_W'(TK)),
    .CAL_CYCLES (lpcs_pkg::CAL_W'(CK))
  ) dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus), .SAMPLE(smp), .RDATA(rdata), .IRQ(irq),
    .LINEFEED_STATE(lf), .DRIVE_ENABLE(drv_en), .CAL_ACTIVE(cal_act),
    .CAL_TARGET_OVERRIDE(cal_ovr), .SAMPLE_TICK(tick)
  );
  function automatic logic [7:0] exp_rb(input int s);
    return (s < 6) ? smp.q_power[s] : 8'h00;
  endfunction
  function automatic logic [7:0] alarm_bit(input int i);
    return 8'h04 << i;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= x;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic iwr(input logic [7:0] idx, input logic [15:0] x);
    wr(lpcs_pkg::ADDR_IND_DATA_LO, x[7:0]);
    wr(lpcs_pkg::ADDR_IND_DATA_HI, x[15:8]);
    wr(lpcs_pkg::ADDR_IND_WRITE, idx);
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge ref_clk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk("linefeed_reset", lf, 0);
    foreach (regs[k])
    begin
      rd(regs[k]);
      chk("reset_value", d, 0);
    end
    foreach (rw_a[k])
    begin
      v = 8'($random(seed));
      wr(rw_a[k], v);
      rd(rw_a[k]);
      chk("rw_value", d, v & rw_m[k]);
    end
    wr(8'h55, 8'hff);
    rd(8'h55);
    chk("unmapped", d, 0);
    // poles and thresholds still zero here, so no alarm can fire yet
    @(posedge ref_clk);
    smp.q_power <= 48'($random(seed)) ^ {16'($random(seed)), 32'h0};
    ticks(3);
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h4c, 8'(s));
      rd(8'h4d);
      chk("power_readback", d, exp_rb(s));
    end
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk);
      smp.q_power <= 48'h80 << (8 * i);
      wr(8'h43, 8'(i % 2));
      wr(8'h40, 8'h01);
      wr(8'h16, alarm_bit(i));
      iwr(8'h25 + 8'(i / 2), 16'h7fff);
      iwr(8'h20 + 8'(i / 2), 16'h0000);
      ticks(4);
      rd(8'h13);
      chk("alarm_pending", d, alarm_bit(i));
      chk("alarm_irq", irq, 1);
      chk("auto_open", lf, (i % 2) ? 0 : 1);
      chk("drive_enable", drv_en, (i % 2) ? 0 : 1);
      // a full-scale threshold stops re-arming while the filter drains
      iwr(8'h20 + 8'(i / 2), 16'hffff);
      smp.q_power <= '0;
      ticks(3);
      rd(8'h13);
      chk("alarm_sticky", d, alarm_bit(i));
      wr(8'h13, 8'hff);
      rd(8'h13);
      chk("alarm_clear", d, 0);
      chk("irq_clear", irq, 0);
    end
    wr(8'h40, 8'h00);
    wr(8'h45, 8'h00);
    wr(8'h6c, 8'h00);
    wr(8'h16, 8'h02);
    iwr(8'h23, 16'h1fff);
    iwr(8'h1c, 16'd20);
    iwr(8'h2b, 16'd10);
    smp.loop_i_mag <= 6'd40;
    smp.loop_v_mag <= 6'd40;
    ticks(8);
    rd(8'h44);
    chk("loop_open_state", d, 0);
    wr(8'h40, 8'h02);
    foreach (lm[k])
    begin
      wr(8'h6c, lm[k]);
      smp.loop_i_mag <= lg[k];
      smp.loop_v_mag <= lg[k];
      ticks(8);
      rd(8'h44);
      chk("loop_status", d, {7'h0, le[k]});
    end
    rd(8'h13);
    chk("loop_pending", d, 8'h02);
    chk("loop_irq", irq, 1);
    wr(8'h13, 8'hff);
    wr(8'h45, 8'd20);
    wr(8'h6c, 8'h00);
    smp.loop_i_mag <= 6'd5;
    ticks(10);
    rd(8'h44);
    chk("debounce_hold", d, 8'h01);
    ticks(20);
    rd(8'h44);
    chk("debounce_flip", d, 8'h00);
    rd(8'h13);
    chk("release_pending", d, 8'h02);
    wr(8'h60, 8'h80);
    rd(8'h60);
    chk("cal_busy", d[7], 1);
    chk("cal_override", cal_ovr, 1);
    repeat (CK) @(posedge ref_clk);
    rd(8'h60);
    chk("cal_done", d[7], 0);
    chk("cal_idle", cal_act, 0);
    test_done();
  end
endmodule
bind lpcs_supervisor lpcs_supervisor_asserts #(
  .TICK_CYCLES(TICK_CYCLES),
  .CAL_CYCLES (CAL_CYCLES)
) u_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .BUS(BUS), .SAMPLE(SAMPLE), .RDATA(RDATA), .IRQ(IRQ),
  .LINEFEED_STATE(LINEFEED_STATE), .DRIVE_ENABLE(DRIVE_ENABLE), .CAL_ACTIVE(CAL_ACTIVE),
  .CAL_TARGET_OVERRIDE(CAL_TARGET_OVERRIDE), .SAMPLE_TICK(SAMPLE_TICK)
);
